/* File: logic/irq_status_map.vh */
// register offsets, field positions, reset values and vector table for the interrupt block
// assumes byte-wide registers placed one per aligned wishbone word
`ifndef IRQ_STATUS_MAP_VH
`define IRQ_STATUS_MAP_VH
`define GLOBAL_IE_IDX 8'h20
`define ENDPOINT_IE_IDX 8'h21
`define STATUS_CTRL_IDX 8'hff
`define CPU_CTRL_IDX 8'h80
`define STAT_RUN 0
`define STAT_RSVD 1
`define STAT_GIE 2
`define STAT_SUSPEND 3
`define STAT_SUPPLY 4
`define STAT_BUS_EVENT 5
`define STAT_WATCHDOG 6
`define STAT_PENDING 7
`define STATUS_POR_VAL 8'h11
`define ENDPOINT_IE_MASK 8'h07
`define NUM_SOURCES 11
`define RESET_VECTOR 16'h0000
`define VECTOR_BASE 16'h0002
`define WAKE_DELAY_CYCLES 4'h8
`endif

/* File: logic/irq_status_ctrl.v */
// interrupt controller with processor status and control register
// assumes: wishbone classic slave on clk_i; event and instruction strobes are
// one-cycle pulses from logic on the same clock; rst_b_i is the low-supply reset
//
// Summary of operation
// [RULE1] stop instruction clears run bit 0; halt holds until a reset; the code also restarts on a status write with bit 0 set
// [RULE2] software writes zero into reserved status bit 1
// [RULE3] status bit 2 reads global enable; writes to it do nothing
// [RULE4] writing 1 to bit 3 suspends; enabled pending irq or bus activity wakes
// [RULE5] suspend requested with wake condition present still enters then wakes
// [RULE6] power-on reset sets supply reset flag bit 4
// [RULE7] bit 5 set by lasting bus event even if disabled; firmware clears
// [RULE8] bit 6 set by a watchdog-initiated reset
// [RULE9] bit 7 shows a pending request; acknowledge clears it
// [RULE10] power-up or low-supply reset loads status 00010001
// [RULE11] watchdog reset loads 01xx0001, keeping bits 5 and 4
// [RULE12] global enable bits 7..0 gate wake, port, capb, capa, serial, timers, bus
// [RULE13] endpoint enable bits 2..0 gate endpoints 2, 1, 0
// [RULE14] any reset clears both enable registers and global enable
// [RULE15] each source has a pending flop held until serviced or reset
// [RULE16] only enabled pending sources request; highest taken at instruction end
// [RULE17] acknowledge clears global enable, then pending bit, then calls vector
// [RULE18] acknowledge call pushes program counter, carry and zero flags
// [RULE19] return from service restores pc and flags and sets global enable
// [RULE20] mask and unmask instructions change only global enable
// [RULE21] priority runs vector 1 at 0x0002 down to vector 11 at 0x0016
// [RULE22] execution starts at 0x0000 after reset; vectors are two bytes apart
`include "irq_status_map.vh"
module irq_status_ctrl (
	input wire clk_i,
	input wire rst_b_i,
	input wire watchdog_reset_event_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [9:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [10:0] source_event_i,
	input wire bus_event_lasting_i,
	input wire bus_activity_i,
	input wire instr_end_i,
	input wire stop_instruction_i,
	input wire mask_all_instruction_i,
	input wire unmask_all_instruction_i,
	input wire return_from_service_instruction_i,
	input wire [15:0] return_pc_i,
	input wire return_carry_flag_i,
	input wire return_zero_flag_i,
	input wire [15:0] pc_i,
	input wire carry_flag_i,
	input wire zero_flag_i,
	output reg ack_call_o,
	output reg [15:0] vector_addr_o,
	output reg [17:0] stack_push_data_o,
	output reg restore_o,
	output reg [17:0] restore_data_o,
	output reg cpu_run_o,
	output reg suspend_o,
	output reg wake_start_o,
	output reg [10:0] pending_o
);

////////////////////////////////////////////////////////////////////////////////
// bus decode
// a request is taken while ack is low; a write lands at the edge that sees ack high
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
wire [7:0] wb_idx = wb_adr_i[9:2];
wire wr_gie = wb_wr & (wb_idx == `GLOBAL_IE_IDX);
wire wr_epie = wb_wr & (wb_idx == `ENDPOINT_IE_IDX);
wire wr_stat = wb_wr & (wb_idx == `STATUS_CTRL_IDX);
wire wr_cpu = wb_wr & (wb_idx == `CPU_CTRL_IDX);

////////////////////////////////////////////////////////////////////////////////
// state
reg [7:0] global_ie_r;
reg [7:0] endpoint_ie_r;
reg cpu_gie_r;
reg run_r;
reg supply_flag_r;
reg bus_flag_r;
reg wdog_flag_r;
reg [10:0] pend_r;
reg suspend_r;
reg [3:0] wake_cnt_r;
reg waking_r;
reg wdog_seen_r;
reg bus_act_meta_r;
reg bus_act_sync_r;

// per-source enable, vector order 1..11
wire [10:0] src_en;
assign src_en[0] = global_ie_r[0]; // RULE12
assign src_en[1] = global_ie_r[1]; // RULE12
assign src_en[2] = global_ie_r[2]; // RULE12
assign src_en[3] = endpoint_ie_r[0]; // RULE13
assign src_en[4] = endpoint_ie_r[1]; // RULE13
assign src_en[5] = endpoint_ie_r[2]; // RULE13
assign src_en[6] = global_ie_r[3]; // RULE12
assign src_en[7] = global_ie_r[4]; // RULE12
assign src_en[8] = global_ie_r[5]; // RULE12
assign src_en[9] = global_ie_r[6]; // RULE12
assign src_en[10] = global_ie_r[7]; // RULE12
wire [10:0] req = pend_r & src_en; // RULE16

// highest priority is lowest index
reg [3:0] sel_idx;
reg sel_valid;
integer k;
always @* begin
	sel_idx = 4'h0;
	sel_valid = 1'b0;
	for (k = `NUM_SOURCES - 1; k >= 0; k = k - 1) begin
		if (req[k]) begin
			sel_idx = k[3:0]; // RULE21
			sel_valid = 1'b1;
		end
	end
end

wire take_irq = sel_valid & cpu_gie_r & instr_end_i & run_r & ~suspend_r; // RULE16
wire wake_cond = (|req) | bus_act_sync_r; // RULE4
wire [7:0] status_rd;
assign status_rd[`STAT_RUN] = run_r;
assign status_rd[`STAT_RSVD] = 1'b0;
assign status_rd[`STAT_GIE] = cpu_gie_r; // RULE3
assign status_rd[`STAT_SUSPEND] = suspend_r;
assign status_rd[`STAT_SUPPLY] = supply_flag_r;
assign status_rd[`STAT_BUS_EVENT] = bus_flag_r;
assign status_rd[`STAT_WATCHDOG] = wdog_flag_r;
assign status_rd[`STAT_PENDING] = |pend_r; // RULE9

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for the bus activity pin
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		bus_act_meta_r <= 1'b0;
		bus_act_sync_r <= 1'b0;
	end else begin
		bus_act_meta_r <= bus_activity_i;
		bus_act_sync_r <= bus_act_meta_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pending flops, set wins over acknowledge clear
genvar g;
generate
	for (g = 0; g < `NUM_SOURCES; g = g + 1) begin : pend_gen
		always @(posedge clk_i) begin
			if (!rst_b_i || watchdog_reset_event_i) begin
				pend_r[g] <= 1'b0; // RULE15
			end else if (source_event_i[g]) begin
				pend_r[g] <= 1'b1; // RULE15
			end else if (take_irq && sel_idx == g) begin
				pend_r[g] <= 1'b0; // RULE17
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// interrupt enable registers
always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		global_ie_r <= 8'h00; // RULE14
	end else if (wr_gie) begin
		global_ie_r <= wb_dat_i[7:0]; // RULE12
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		endpoint_ie_r <= 8'h00; // RULE14
	end else if (wr_epie) begin
		endpoint_ie_r <= wb_dat_i[7:0] & `ENDPOINT_IE_MASK; // RULE13
	end
end

////////////////////////////////////////////////////////////////////////////////
// cpu global enable: acknowledge and mask win over unmask and return
always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		cpu_gie_r <= 1'b0; // RULE14
	end else if (take_irq || mask_all_instruction_i) begin
		cpu_gie_r <= 1'b0; // RULE17 RULE20
	end else if (unmask_all_instruction_i || return_from_service_instruction_i) begin
		cpu_gie_r <= 1'b1; // RULE19 RULE20
	end
end

////////////////////////////////////////////////////////////////////////////////
// status register bits
always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		run_r <= 1'b1; // RULE10 RULE11
	end else if (stop_instruction_i) begin
		run_r <= 1'b0; // RULE1
	end else if (wr_stat) begin
		run_r <= wb_dat_i[`STAT_RUN];
	end
end

// supply flag survives a watchdog reset
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		supply_flag_r <= 1'b1; // RULE6 RULE10
	end else if (watchdog_reset_event_i) begin
		supply_flag_r <= supply_flag_r; // RULE11
	end else if (wr_stat) begin
		supply_flag_r <= wb_dat_i[`STAT_SUPPLY];
	end
end

// bus event flag: a lasting event wins over a firmware write
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		bus_flag_r <= 1'b0; // RULE10
	end else if (watchdog_reset_event_i) begin
		bus_flag_r <= bus_flag_r; // RULE11
	end else if (bus_event_lasting_i) begin
		bus_flag_r <= 1'b1; // RULE7
	end else if (wr_stat) begin
		bus_flag_r <= wb_dat_i[`STAT_BUS_EVENT]; // RULE7
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i) begin
		wdog_flag_r <= 1'b0; // RULE10
	end else if (watchdog_reset_event_i) begin
		wdog_flag_r <= 1'b1; // RULE8 RULE11
	end else if (wr_stat) begin
		wdog_flag_r <= wb_dat_i[`STAT_WATCHDOG];
	end
end

////////////////////////////////////////////////////////////////////////////////
// suspend: entered even if a wake condition is already present
wire wake_done = waking_r && (wake_cnt_r == `WAKE_DELAY_CYCLES);
wire suspend_req = wr_stat && wb_dat_i[`STAT_SUSPEND];

always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		suspend_r <= 1'b0;
	end else if (suspend_req) begin
		suspend_r <= 1'b1; // RULE4 RULE5
	end else if (suspend_r && wake_done) begin
		suspend_r <= 1'b0; // RULE5
	end
end

// wake condition is latched once, then the clock start-up delay runs
always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		waking_r <= 1'b0;
	end else if (suspend_req) begin
		waking_r <= 1'b0;
	end else if (suspend_r && wake_done) begin
		waking_r <= 1'b0;
	end else if (suspend_r && wake_cond) begin
		waking_r <= 1'b1; // RULE4 RULE5
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		wake_cnt_r <= 4'h0;
	end else if (suspend_req) begin
		wake_cnt_r <= 4'h0;
	end else if (suspend_r && waking_r && !wake_done) begin
		wake_cnt_r <= wake_cnt_r + 4'h1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// watchdog event registered one cycle for the cpu control read; bits 5 and 4 are kept via separate branches above
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		wdog_seen_r <= 1'b0;
	end else begin
		wdog_seen_r <= watchdog_reset_event_i;
	end
end

////////////////////////////////////////////////////////////////////////////////
// acknowledge call and return to the core
always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		ack_call_o <= 1'b0;
	end else begin
		ack_call_o <= take_irq; // RULE17
	end
end

// vector and stacked state are only loaded by an acknowledge
always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		vector_addr_o <= `RESET_VECTOR; // RULE22
		stack_push_data_o <= 18'h0;
	end else if (take_irq) begin
		vector_addr_o <= `VECTOR_BASE + {11'h000, sel_idx, 1'b0}; // RULE21 RULE22
		stack_push_data_o <= {pc_i, carry_flag_i, zero_flag_i}; // RULE18
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		restore_o <= 1'b0;
	end else begin
		restore_o <= return_from_service_instruction_i; // RULE19
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i || watchdog_reset_event_i) begin
		restore_data_o <= 18'h0;
	end else if (return_from_service_instruction_i) begin
		restore_data_o <= {return_pc_i, return_carry_flag_i, return_zero_flag_i}; // RULE19
	end
end

////////////////////////////////////////////////////////////////////////////////
// wishbone answer: ack one cycle after the request, read data with it
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		wb_ack_o <= 1'b0;
	end else begin
		wb_ack_o <= wb_req;
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i) begin
		wb_dat_o <= 32'h00000000;
	end else if (wb_req && !wb_we_i) begin
		case (wb_idx)
			`GLOBAL_IE_IDX: wb_dat_o <= {24'h000000, global_ie_r};
			`ENDPOINT_IE_IDX: wb_dat_o <= {24'h000000, endpoint_ie_r};
			`STATUS_CTRL_IDX: wb_dat_o <= {24'h000000, status_rd}; // RULE3 RULE9
			`CPU_CTRL_IDX: wb_dat_o <= {29'h0000000, wdog_seen_r, waking_r,
				suspend_r};
			default: wb_dat_o <= 32'h00000000;
		endcase
	end else begin
		wb_dat_o <= 32'h00000000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// core-facing status outputs
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		cpu_run_o <= 1'b0;
	end else begin
		cpu_run_o <= run_r & ~suspend_r; // RULE1 RULE4
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i) begin
		suspend_o <= 1'b0;
	end else begin
		suspend_o <= suspend_r;
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i) begin
		wake_start_o <= 1'b0;
	end else begin
		wake_start_o <= suspend_r & ~waking_r & wake_cond;
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i) begin
		pending_o <= 11'h000;
	end else begin
		pending_o <= pend_r; // RULE15
	end
end

endmodule // irq_status_ctrl

/* File: dv/irq_status_ctrl_asserts.sv */
// port assertions for the interrupt and status block
// bound into every irq_status_ctrl; single clock domain
module irq_status_ctrl_checker (
	input wire clk_i,
	input wire rst_b_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire instr_end_i,
	input wire stop_instruction_i,
	input wire return_from_service_instruction_i,
	input wire [15:0] pc_i,
	input wire ack_call_o,
	input wire [15:0] vector_addr_o,
	input wire [17:0] stack_push_data_o,
	input wire restore_o,
	input wire cpu_run_o,
	input wire suspend_o,
	input wire bus_activity_i
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	bus_ack_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no bus ack");
	call_pulse_a: assert property (ack_call_o |=> !ack_call_o)
		else $error("call held");
	vec_range_a: assert property (ack_call_o |-> !vector_addr_o[0] &&
		vector_addr_o >= 16'h0002 && vector_addr_o <= 16'h0016) else $error("bad vector");
	push_pc_a: assert property (ack_call_o |-> stack_push_data_o[17:2] == $past(pc_i))
		else $error("bad push");
	call_end_a: assert property (ack_call_o |-> $past(instr_end_i))
		else $error("call mid instruction");
	restore_a: assert property (return_from_service_instruction_i |=> restore_o)
		else $error("no restore");
	stop_halt_a: assert property (stop_instruction_i |-> ##[1:3] !cpu_run_o)
		else $error("no halt");
	wake_up_a: assert property (suspend_o && bus_activity_i |-> ##[1:14] !suspend_o)
		else $error("no wake");
	cover property (ack_call_o);
	cover property (restore_o);
	cover property (suspend_o && bus_activity_i);
endmodule // irq_status_ctrl_checker
bind irq_status_ctrl irq_status_ctrl_checker irq_status_ctrl_checker_i (.*);

/* File: dv/core_model.sv */
// behavioural core: instruction ends, program counter, return stack
// same clock and reset as the interrupt block
module core_model (
	input wire clk_i,
	input wire rst_b_i,
	input wire ack_call_i,
	input wire [17:0] push_i,
	input wire ret_req_i,
	output logic instr_end_o,
	output logic ret_o,
	output logic [17:0] state_o,
	output logic [17:0] pop_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [17:0] stk[$];
	always @(posedge clk_i) begin
		instr_end_o <= rst_b_i & ~instr_end_o;
		state_o <= rst_b_i ? state_o + 18'h15 : 18'h0;
		ret_o <= ret_req_i;
		pop_o <= ret_req_i ? stk.pop_back() : ~pop_o;
		if (ack_call_i) stk.push_back(push_i);
	end
endmodule // core_model

/* File: dv/tb_irq_status_ctrl.sv */
// self-checking bench for the interrupt and status block
// core model supplies instruction ends, program counter and stack
module tb_irq_status_ctrl;
timeunit 1ns;
timeprecision 100ps;
logic clk_i = 1'h0;
logic rst_b_i = 1'h0;
logic wb_cyc_i = 1'h0;
logic wb_we_i = 1'h0;
logic bus_activity_i = 1'h0;
logic [3:0] wb_sel_i = 4'h1;
logic [9:0] wb_adr_i = 10'h0;
logic [31:0] wb_dat_i = 32'h0;
logic [10:0] source_event_i = 11'h0;
logic [5:0] ctl = 6'h0;
logic [31:0] rd, n;
int bad_count = 0, compares = 0, cyc_n = 0;
wire wb_stb_i = wb_cyc_i;
wire rrq, watchdog_reset_event_i, bus_event_lasting_i, stop_instruction_i, instr_end_i;
wire mask_all_instruction_i, unmask_all_instruction_i, return_from_service_instruction_i;
wire carry_flag_i, zero_flag_i, return_carry_flag_i, return_zero_flag_i, restore_o;
wire wb_ack_o, ack_call_o, cpu_run_o, suspend_o, wake_start_o;
wire [15:0] pc_i, return_pc_i, vector_addr_o;
wire [17:0] st, pop, stack_push_data_o, restore_data_o;
wire [31:0] wb_dat_o;
wire [10:0] pending_o;
assign {rrq, watchdog_reset_event_i, bus_event_lasting_i, stop_instruction_i,
	mask_all_instruction_i, unmask_all_instruction_i} = ctl;
assign {pc_i, carry_flag_i, zero_flag_i} = st;
assign {return_pc_i, return_carry_flag_i, return_zero_flag_i} = pop;
irq_status_ctrl irq_status_ctrl_i (.*);
core_model core_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ack_call_i(ack_call_o),
	.push_i(stack_push_data_o), .ret_req_i(rrq), .instr_end_o(instr_end_i),
	.ret_o(return_from_service_instruction_i), .state_o(st), .pop_o(pop));
initial forever #4 clk_i = ~clk_i;
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
	compares++;
	if (g !== e) begin
		bad_count++;
		$display("wrong value %s exp %h got %h", s, e, g);
	end
endtask
task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
	wb_adr_i <= a;
	wb_we_i <= w;
	wb_dat_i <= {24'h0, d};
	wb_cyc_i <= 1'h1;
	do @(posedge clk_i); while (wb_ack_o !== 1'h1);
	rd = wb_dat_o;
	wb_cyc_i <= 1'h0;
	@(posedge clk_i);
endtask
task automatic rdc(input logic [9:0] a, input logic [7:0] e);
	bus(a, 1'h0, 8'h0);
	chk("register", {24'h0, e}, rd);
endtask
// one-cycle core strobe: rrq, watchdog, bus event, stop, mask, unmask
task automatic op(input logic [5:0] v);
	ctl <= v;
	@(posedge clk_i);
	ctl <= 6'h0;
	@(posedge clk_i);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic reset_vals;
	chk("vector", 32'h0, vector_addr_o);
	rdc(10'h3fc, 8'h11);
	rdc(10'h080, 8'h0);
	rdc(10'h084, 8'h0);
endtask
task automatic irq_order;
	source_event_i <= 11'h7ff;
	@(posedge clk_i);
	source_event_i <= 11'h0;
	op(6'h01);
	n = 0;
	repeat (8) @(posedge clk_i) n += ack_call_o;
	chk("calls", 32'h0, n);
	op(6'h02);
	chk("pending", 32'h7ff, pending_o);
	rdc(10'h3fc, 8'h91);
	bus(10'h080, 1'h1, 8'hff);
	bus(10'h084, 1'h1, 8'hff);
	for (int i = 0; i < 11; i++) begin
		op(6'h01);
		do @(posedge clk_i); while (ack_call_o !== 1'h1);
		chk("vector", 32'(2 + 2 * i), vector_addr_o);
	end
	rdc(10'h3fc, 8'h11);
	chk("pending", 32'h0, pending_o);
	op(6'h20);
	rdc(10'h3fc, 8'h15);
endtask
task automatic reg_access;
	rdc(10'h080, 8'hff);
	rdc(10'h084, 8'h07);
	bus(10'h010, 1'h1, 8'hff);
	rdc(10'h010, 8'h0);
	bus(10'h3fc, 1'h1, 8'h01);
	rdc(10'h3fc, 8'h05);
	op(6'h02);
	rdc(10'h3fc, 8'h01);
endtask
task automatic status_flags;
	op(6'h08);
	rdc(10'h3fc, 8'h21);
	op(6'h04);
	repeat (20) @(posedge clk_i);
	chk("run", 32'h0, cpu_run_o);
	op(6'h10);
	rdc(10'h3fc, 8'h61);
	rdc(10'h080, 8'h0);
	chk("run", 32'h1, cpu_run_o);
endtask
task automatic suspend_wake;
	bus(10'h3fc, 1'h1, 8'h69);
	do @(posedge clk_i); while (suspend_o !== 1'h1);
	bus_activity_i <= 1'h1;
	do @(posedge clk_i); while (suspend_o !== 1'h0);
	bus(10'h3fc, 1'h1, 8'h69);
	@(posedge clk_i);
	chk("suspend", 32'h1, suspend_o);
	do @(posedge clk_i); while (suspend_o !== 1'h0);
	repeat (2) @(posedge clk_i);
	chk("run", 32'h1, cpu_run_o);
	bus_activity_i <= 1'h0;
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic report_and_stop;
	if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
always @(posedge clk_i) begin
	cyc_n <= cyc_n + 1;
	if (cyc_n == 3000) begin
		bad_count++;
		report_and_stop;
	end
end
initial begin
	repeat (16) @(posedge clk_i);
	rst_b_i <= 1'h1;
	@(posedge clk_i);
	reset_vals;
	irq_order;
	reg_access;
	status_flags;
	suspend_wake;
	report_and_stop;
end
endmodule // tb_irq_status_ctrl
